// >>> swgs_top.sv
// Global identification, start-up policy and control byte zero of the switch
// Behaviour
// - Host mode (1,0): switching starts only once host writes start bit one.
// - Writing start bit zero halts switching; registers stay accessible.
// - Mode (0,0): try EEPROM after reset, then start switching unaided.
// - No EEPROM answer: every register except the start bit keeps its reset default.
// - EEPROM image checked: byte 0 family code, byte 1 upper nibble chip id.
// - EEPROM contents replace defaults only when that check passes.
// - Control byte zero bit 7 selects alternative back-off; resets to zero.
// - Control byte zero bit 5 triggers table purge, self-clears when done.
// - Purge removes only entries of ports with learning disabled.
// - 256 byte registers on 8-bit address; upper read data bits are zero.
`timescale 1ns/10ps
module swgs_top
   import swgs_pkg::*;
#(
   parameter logic [7:0] FAMILY_CODE = 8'hA5, // Arbitrary value
   parameter logic [3:0] CHIP_ID = 4'h3, // Arbitrary value
   parameter logic [2:0] REVISION = 3'h1, // Arbitrary value
   parameter int DEPTH = 1024,
   parameter int NPORT = 4,
   parameter int AW = $clog2(DEPTH),
   parameter int PW = $clog2(NPORT)
)(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Mode straps
   input wire logic config_mode_pin_high,
   input wire logic config_mode_pin_low,
   // Decoded management register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // EEPROM byte fetch
   output logic ee_req,
   output logic [7:0] ee_addr,
   input wire logic ee_ack,
   input wire logic ee_nack,
   input wire logic [7:0] ee_data,
   // Switch core controls
   output logic switch_run,
   output logic alt_backoff,
   // Address table purge
   input wire logic [NPORT-1:0] learn_dis,
   input wire logic entry_valid,
   input wire logic [PW-1:0] entry_port,
   output logic [AW-1:0] purge_idx,
   output logic purge_clear,
   output logic [AW-1:0] purge_clr_idx
);
   swgs_boot_e boot_q, boot_d;
   logic [1:0] mode_q;
   logic start_q, start_d;
   logic alt_q, alt_d;
   logic purge_q, purge_d;
   logic run_q, run_d;
   logic fam_ok_q;
   logic req_q;
   logic [7:0] ee_addr_q;
   logic [15:0] rdata_q;
   logic purge_busy, purge_done;

   // Register decode
   wire wr_start = reg_wr & (reg_addr == OFF_REV_START);
   wire wr_gc0 = reg_wr & (reg_addr == OFF_GCTRL0);
   wire [7:0] byte_family = FAMILY_CODE;
   wire [7:0] byte_rev = {CHIP_ID, REVISION, start_q};
   wire [7:0] byte_gc0 = {alt_q, 1'b0, purge_q, 5'h00};
   // Rest of the map lives in other blocks; here it reads zero
   wire [7:0] rd_byte = (reg_addr == OFF_FAMILY) ? byte_family :
                        (reg_addr == OFF_REV_START) ? byte_rev :
                        (reg_addr == OFF_GCTRL0) ? byte_gc0 : 8'h00;
   wire [15:0] rdata_d = reg_rd ? {8'h00, rd_byte} : rdata_q;

   // Boot loader
   wire fetching = (boot_q == BOOT_FETCH);
   wire ee_take = fetching & ee_ack;
   wire ee_fail = fetching & ee_nack & ~ee_ack;
   wire nib_ok = (ee_data[7:4] == CHIP_ID);
   wire chk_bad = ee_take & (ee_addr_q == OFF_REV_START) & ~(fam_ok_q & nib_ok);
   wire load_gc0 = ee_take & (ee_addr_q == EE_LAST);
   wire boot_end = ee_fail | chk_bad | load_gc0;
   wire run_mode = (mode_q == MODE_AUTO) | (mode_q == MODE_HOST);

   always_comb
   begin
      boot_d = boot_q;
      unique case (boot_q)
         BOOT_STRAP: boot_d = ({config_mode_pin_high, config_mode_pin_low} == MODE_AUTO) ?
                              BOOT_FETCH : BOOT_DONE;
         BOOT_FETCH: boot_d = boot_end ? BOOT_DONE : BOOT_FETCH;
         BOOT_DONE: boot_d = BOOT_DONE;
      endcase
   end

   // Auto mode sets start itself, a later host write of zero still halts
   assign start_d = boot_end ? 1'b1 : wr_start ? reg_wdata[BIT_START] : start_q;
   assign alt_d = wr_gc0 ? reg_wdata[BIT_ALT_BACKOFF] :
                  load_gc0 ? ee_data[BIT_ALT_BACKOFF] : alt_q;
   // A fresh trigger in the done cycle wins over the self-clear
   assign purge_d = (wr_gc0 & reg_wdata[BIT_PURGE]) ? 1'b1 : purge_done ? 1'b0 : purge_q;
   // Registers stay reachable while halted; only forwarding stops
   assign run_d = start_q & (boot_q == BOOT_DONE) & run_mode;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         boot_q <= BOOT_STRAP;
         start_q <= RST_START;
         alt_q <= RST_ALT_BACKOFF;
         purge_q <= RST_PURGE;
         run_q <= 1'b0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         boot_q <= boot_d;
         start_q <= start_d;
         alt_q <= alt_d;
         purge_q <= purge_d;
         run_q <= run_d;
         rdata_q <= rdata_d;
      end
   end

   // Strap capture and EEPROM request, taken on the first edge after release
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         mode_q <= 2'h0;
         fam_ok_q <= 1'b0;
         req_q <= 1'b0;
         ee_addr_q <= 8'h00;
      end
      else
      begin
         if (boot_q == BOOT_STRAP)
            mode_q <= {config_mode_pin_high, config_mode_pin_low};
         if (boot_q == BOOT_STRAP)
            req_q <= (boot_d == BOOT_FETCH);
         else if (boot_end)
            req_q <= 1'b0;
         if (ee_take & (ee_addr_q == OFF_FAMILY))
            fam_ok_q <= (ee_data == FAMILY_CODE);
         if (ee_take & ~boot_end)
            ee_addr_q <= ee_addr_q + 8'h01;
      end
   end

   swgs_purge #(
      .DEPTH(DEPTH),
      .NPORT(NPORT),
      .AW(AW),
      .PW(PW)
   ) u_purge (
      .mclk(mclk),
      .reset_n(reset_n),
      .start(purge_q & ~purge_busy & ~purge_done),
      .learn_dis(learn_dis),
      .entry_valid(entry_valid),
      .entry_port(entry_port),
      .idx_q(purge_idx),
      .clear_q(purge_clear),
      .clr_idx_q(purge_clr_idx),
      .busy_q(purge_busy),
      .done_q(purge_done)
   );

   assign reg_rdata = rdata_q;
   assign ee_req = req_q;
   assign ee_addr = ee_addr_q;
   assign switch_run = run_q;
   assign alt_backoff = alt_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence auto_start_s;
      start_q ##1 switch_run;
   endsequence
   sequence halt_s;
      !start_q ##1 !switch_run;
   endsequence

   run_cause_a: assert property ($rose(switch_run) |-> $past(start_q) && run_mode)
      else $error("switching began without start bit or allowed mode");
   halt_a: assert property (wr_start && !reg_wdata[BIT_START] && !boot_end |=> halt_s)
      else $error("start bit zero did not halt switching");
   auto_start_a: assert property (boot_end && mode_q == MODE_AUTO |=> auto_start_s)
      else $error("automatic start did not follow boot");
   no_eeprom_a: assert property (ee_fail |=> boot_q == BOOT_DONE && !ee_req
      && alt_q == $past(alt_q) || $past(wr_gc0))
      else $error("missing EEPROM disturbed defaults");
   id_check_a: assert property (ee_take && ee_addr_q == OFF_REV_START
      && !(fam_ok_q && ee_data[7:4] == CHIP_ID) |=> boot_q == BOOT_DONE && !ee_req)
      else $error("bad image was not rejected");
   load_gate_a: assert property ($changed(alt_q) |-> $past(wr_gc0) || $past(load_gc0))
      else $error("back-off bit changed without write or good image");
   backoff_wr_a: assert property (wr_gc0 |=> alt_backoff == $past(reg_wdata[BIT_ALT_BACKOFF]))
      else $error("back-off bit did not take written value");
   purge_sc_a: assert property ($fell(purge_q) |-> $past(purge_done)
      && !$past(wr_gc0 && reg_wdata[BIT_PURGE]))
      else $error("purge bit cleared without completion");
   upper_zero_a: assert property (reg_rd |=> reg_rdata[15:8] == 8'h00)
      else $error("upper read data not zero");
   fixed_id_a: assert property (reg_rd && reg_addr == OFF_REV_START
      |=> reg_rdata[7:1] == {CHIP_ID, REVISION})
      else $error("identity field not fixed");
   reserved_a: assert property (reg_rd && reg_addr == OFF_GCTRL0 |=> reg_rdata[6] == 1'b0)
      else $error("reserved bit 6 not zero");
endmodule // swgs_top

// >>> swgs_pkg.sv
// Shared constants for the switch global start-up control block
package swgs_pkg;
   // Register offsets on the 8-bit management address
   localparam logic [7:0] OFF_FAMILY = 8'h00;
   localparam logic [7:0] OFF_REV_START = 8'h01;
   localparam logic [7:0] OFF_GCTRL0 = 8'h02;
   // Field positions
   localparam int BIT_START = 0;
   localparam int BIT_ALT_BACKOFF = 7;
   localparam int BIT_PURGE = 5;
   // Reset values of the writable bits
   localparam logic RST_START = 1'b0;
   localparam logic RST_ALT_BACKOFF = 1'b0;
   localparam logic RST_PURGE = 1'b0;
   // Mode pin codes {high, low}
   localparam logic [1:0] MODE_AUTO = 2'h0;
   localparam logic [1:0] MODE_HOST = 2'h2;
   // Last EEPROM byte fetched by the boot loader
   localparam logic [7:0] EE_LAST = 8'h02;
   typedef enum logic [1:0] {BOOT_STRAP, BOOT_FETCH, BOOT_DONE} swgs_boot_e;
endpackage

// >>> swgs_purge.sv
// Dynamic address table purge walker
`timescale 1ns/10ps
module swgs_purge
   import swgs_pkg::*;
#(
   parameter int DEPTH = 1024,
   parameter int NPORT = 4,
   parameter int AW = $clog2(DEPTH),
   parameter int PW = $clog2(NPORT)
)(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Control
   input wire logic start,
   input wire logic [NPORT-1:0] learn_dis,
   // Table walk
   input wire logic entry_valid,
   input wire logic [PW-1:0] entry_port,
   output logic [AW-1:0] idx_q,
   output logic clear_q,
   output logic [AW-1:0] clr_idx_q,
   output logic busy_q,
   output logic done_q
);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   wire hit = busy_q & entry_valid & learn_dis[entry_port];

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         idx_q <= '0;
         clear_q <= 1'b0;
         clr_idx_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         clear_q <= hit;
         clr_idx_q <= idx_q;
         done_q <= busy_q & (idx_q == LAST);
         if (start & ~busy_q)
         begin
            busy_q <= 1'b1;
            idx_q <= '0;
         end
         else if (busy_q)
         begin
            busy_q <= (idx_q != LAST);
            idx_q <= (idx_q == LAST) ? idx_q : idx_q + 1'b1;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   purge_keep_a: assert property (clear_q |-> $past(busy_q) && $past(entry_valid)
      && $past(learn_dis[entry_port]))
      else $error("purge cleared an entry of a learning port");
   purge_walk_a: assert property (start && !busy_q |=> busy_q && idx_q == '0)
      else $error("purge walk did not begin at entry zero");
endmodule // swgs_purge

// >>> swgs_ee_model.sv
// EEPROM and address table model on the far side of the start-up block
`timescale 1ns/10ps
module swgs_ee_model (
   // Clock
   input wire logic mclk,
   // Behaviour set by the bench
   input wire logic present,
   input wire logic [3:0] wait_n,
   input wire logic [23:0] image,
   input wire logic [7:0] tv,
   input wire logic [15:0] tp,
   // EEPROM byte fetch
   input wire logic ee_req,
   input wire logic [7:0] ee_addr,
   output logic ee_ack,
   output logic ee_nack,
   output logic [7:0] ee_data,
   // Table walk
   input wire logic [2:0] purge_idx,
   output logic entry_valid,
   output logic [1:0] entry_port
);
   logic [3:0] cnt = 4'h0;
   initial {ee_ack, ee_nack, ee_data} = 10'h0;
   assign entry_valid = tv[purge_idx[2:0]];
   assign entry_port = tp[2*purge_idx[2:0] +: 2];
   // Data toggles outside an answer so a stale byte is never mistaken for a fresh one
   always @(posedge mclk)
   begin
      ee_ack <= 1'b0;
      ee_nack <= 1'b0;
      ee_data <= ~ee_data;
      if (ee_req && !ee_ack && !ee_nack)
      begin
         if (cnt < wait_n)
            cnt <= cnt + 4'h1;
         else
         begin
            cnt <= 4'h0;
            ee_ack <= present;
            ee_nack <= !present;
            if (present)
               ee_data <= image[8*ee_addr[1:0] +: 8];
         end
      end
   end
endmodule // swgs_ee_model

// >>> switch_global_start_control_tb_top.sv
// Self-checking bench for the switch start-up control block
`timescale 1ns/10ps
module switch_global_start_control_tb_top;
   import swgs_pkg::*;
   logic mclk = 0, reset_n = 0, mh = 0, ml = 0, reg_wr = 0, reg_rd = 0, rd_p = 0;
   logic [7:0] reg_addr = 0, ee_addr, tv = 0;
   logic [15:0] reg_wdata = 0, reg_rdata, tp = 0;
   logic ee_req, ee_ack, ee_nack, switch_run, alt_backoff, present = 0, ev, purge_clear;
   logic [23:0] image = 0;
   logic [7:0] ee_data;
   logic [3:0] learn_dis = 0, wait_n = 0;
   logic [1:0] ep;
   logic [2:0] pidx, cidx;
   logic [15:0] exp_q[$];
   int failures = 0, n_compared = 0, seed = 48, ncl = 0, nexp;
   always #25 mclk = ~mclk;
   swgs_top #(.DEPTH(8)) DUT (.mclk, .reset_n, .config_mode_pin_high(mh),
      .config_mode_pin_low(ml), .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .ee_req, .ee_addr, .ee_ack, .ee_nack, .ee_data, .switch_run, .alt_backoff,
      .learn_dis, .entry_valid(ev), .entry_port(ep), .purge_idx(pidx), .purge_clear,
      .purge_clr_idx(cidx));
   // Answer delay is drawn once per boot so it stays fixed while a fetch is pending
   swgs_ee_model ee (.mclk, .present, .wait_n, .image, .tv, .tp,
      .ee_req, .ee_addr, .ee_ack, .ee_nack, .ee_data, .purge_idx(pidx),
      .entry_valid(ev), .entry_port(ep));
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   task conclude;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Watcher takes the oldest expectation when a read answer lands
   always @(posedge mclk) rd_p <= reg_rd;
   // Every removed index must hold a valid entry of a port with learning off
   always @(posedge mclk)
      if (purge_clear)
      begin
         ncl++;
         chk(16'(tv[cidx] && learn_dis[tp[2*cidx +: 2]]), 16'h0001);
      end
   always @(negedge mclk) if (rd_p) chk(reg_rdata, exp_q.pop_front());
   task rst(input logic [1:0] m);
      @(negedge mclk) reset_n = 0;
      {mh, ml} = m;
      repeat (10) @(negedge mclk);
      reset_n = 1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk) reg_wr = 1;
      reg_addr = a;
      reg_wdata = {8'($random(seed)), d};
      @(negedge mclk) reg_wr = 0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk) reg_rd = 1;
      reg_addr = a;
      exp_q.push_back({8'h00, e});
      @(negedge mclk) reg_rd = 0;
   endtask
   task boot(input logic p, input logic [23:0] img, input logic ea);
      present = p;
      image = img;
      wait_n = 4'($random(seed));
      rst(MODE_AUTO);
      repeat (3) @(negedge mclk);
      for (int i = 0; i < 60 && ee_req === 1'b1; i++) @(negedge mclk);
      repeat (3) @(negedge mclk);
      chk(ee_req, 1'b0);
      chk(switch_run, 1'b1);
      chk(alt_backoff, ea);
      rd(OFF_REV_START, 8'h33);
      $display("Boot test done");
   endtask
   initial
   begin
      #200000 failures++;
      conclude;
   end
   initial
   begin
      rst(MODE_HOST);
      rd(OFF_FAMILY, 8'hA5);
      rd(OFF_REV_START, 8'h32);
      chk(switch_run, 1'b0);
      wr(OFF_FAMILY, 8'hFF);
      wr(OFF_REV_START, 8'hFF);
      rd(OFF_FAMILY, 8'hA5);
      rd(OFF_REV_START, 8'h33);
      rd(8'h80, 8'h00);
      chk(switch_run, 1'b1);
      wr(OFF_REV_START, 8'h00);
      repeat (2) @(negedge mclk);
      chk(switch_run, 1'b0);
      rd(OFF_FAMILY, 8'hA5);
      $display("Host mode test done");
      for (int k = 0; k < 3; k++)
      begin
         tv = 8'($random(seed));
         tp = 16'($random(seed));
         learn_dis = (k == 2) ? 4'hF : 4'($random(seed));
         nexp = 0;
         for (int i = 0; i < 8; i++)
            nexp += (tv[i] && learn_dis[tp[2*i +: 2]]) ? 1 : 0;
         ncl = 0;
         wr(OFF_GCTRL0, 8'hFF);
         rd(OFF_GCTRL0, 8'hA0);
         chk(alt_backoff, 1'b1);
         repeat (20) @(negedge mclk);
         rd(OFF_GCTRL0, 8'h80);
         chk(16'(ncl), 16'(nexp));
         wr(OFF_GCTRL0, 8'h00);
         repeat (2) @(negedge mclk);
         chk(alt_backoff, 1'b0);
      end
      $display("Control byte test done");
      boot(1'b1, 24'h8032A5, 1'b1);
      boot(1'b1, 24'h8032A4, 1'b0);
      boot(1'b1, 24'h8052A5, 1'b0);
      boot(1'b0, 24'h8032A5, 1'b0);
      rd(OFF_GCTRL0, 8'h00);
      for (int m = 1; m < 4; m += 2)
      begin
         rst(2'(m));
         wr(OFF_REV_START, 8'h01);
         repeat (3) @(negedge mclk);
         chk(switch_run, 1'b0);
      end
      $display("Strap mode test done");
      repeat (3) @(negedge mclk);
      conclude;
   end
endmodule // switch_global_start_control_tb_top
